// File: rtl/acs_pkg.sv
// Package for the conversion sequencer: map, fields, counts, types
package acs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL0 = 6'h14;
  localparam logic [5:0] IDX_CTRL1 = 6'h15;
  localparam logic [5:0] IDX_RESL  = 6'h16;
  localparam logic [5:0] IDX_RESH  = 6'h17;
  localparam logic [5:0] IDX_FLAGS = 6'h18;
  localparam logic [5:0] IDX_PORT  = 6'h19;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C0_CHAN_LSB  = 4;
  localparam int C0_GO_BIT    = 2;
  localparam int C0_ON_BIT    = 0;
  localparam int C1_CSEL_LSB  = 6;
  localparam int C1_FMT_BIT   = 5;
  localparam int C1_PCFG_LSB  = 0;
  localparam int FL_IRQEN_BIT = 1;
  localparam int FL_DONE_BIT  = 0;

  // ----------------------------------------------------------------
  // Clock selection and timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CSEL_D8  = 2'h0;
  localparam logic [1:0] CSEL_D32 = 2'h1;
  localparam logic [1:0] CSEL_D64 = 2'h2;
  localparam logic [1:0] CSEL_RC  = 2'h3;
  localparam logic [6:0] DIV_8    = 7'h08;
  localparam logic [6:0] DIV_32   = 7'h20;
  localparam logic [6:0] DIV_64   = 7'h40;
  localparam logic [2:0] INSTR_CYC = 3'h4;
  localparam logic [3:0] CONV_TADS = 4'hC;
  localparam logic [3:0] HOLD_TADS = 4'h2;
  localparam logic [3:0] RES_BITS  = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DELAY,
    PH_FIRST,
    PH_CONV,
    PH_HOLD
  } acs_phase_t;

  typedef struct packed {
    logic [3:0] chan;
    logic       go;
    logic       on;
  } acs_ctrl0_t;

  typedef struct packed {
    logic [1:0] csel;
    logic       fmt;
    logic [3:0] pcfg;
  } acs_ctrl1_t;

  typedef struct packed {
    logic irqen;
    logic done;
  } acs_flags_t;

  typedef struct packed {
    acs_ctrl0_t  c0;
    acs_ctrl1_t  c1;
    acs_flags_t  fl;
    acs_phase_t  ph;
    logic [3:0]  tads;
    logic [9:0]  sar;
    logic [2:0]  dly;
    logic        slp_off;
    logic        power;
    logic        sample;
    logic        wake;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  chan_o;
  } acs_ctl_t;

  typedef struct packed {
    acs_ctl_t   ctl;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
  } acs_state_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       rc_q;
    logic       tick;
  } acs_tad_st_t;

  localparam acs_ctl_t    CTL_RST = '0;
  localparam acs_tad_st_t TAD_RST = '0;

endpackage : acs_pkg

// File: rtl/acs_seq.sv
// Conversion sequencer with APB registers, SAR control and sleep logic
`timescale 1ns/10ps
`default_nettype none

module acs_seq
  import acs_pkg::*;
(
  input  wire logic        REF_CLK_IN,   // 250 MHz core clock
  input  wire logic        RST_N_IN,     // Async reset, low
  input  wire logic        CE_IN,        // Clock enable
  input  wire logic        PSEL_IN,      // APB select
  input  wire logic        PENABLE_IN,   // APB enable
  input  wire logic        PWRITE_IN,    // APB direction
  input  wire logic [7:0]  PADDR_IN,     // APB byte address
  input  wire logic [31:0] PWDATA_IN,    // APB write data
  output logic      [31:0] PRDATA_OUT,   // APB read data
  output logic             PREADY_OUT,   // APB ready
  output logic             PSLVERR_OUT,  // APB error
  input  wire logic        SLEEP_IN,     // Core in sleep
  input  wire logic [15:0] PIN_LEVEL_IN, // Digital pin levels
  input  wire logic        COMP_IN,      // Comparator result
  input  wire logic        RC_OSC_IN,    // Internal RC clock
  output logic             POWER_OUT,    // Converter powered
  output logic             SAMPLE_OUT,   // Hold cap connected
  output logic      [3:0]  CHANNEL_OUT,  // Selected channel
  output logic      [9:0]  TRIAL_OUT,    // SAR trial code
  output logic             WAKE_OUT      // Wake pulse
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  acs_state_t  st_reg;
  acs_state_t  st_next;
  acs_ctl_t    s;
  logic [17:0] sync_q;
  logic [15:0] pins;
  logic        comp;
  logic        rc_lvl;
  logic        tick;
  logic        restart;
  logic [5:0]  idx;
  logic        acc;
  logic        wr;
  logic        w0;
  logic        busy;
  logic        pd_sleep;
  logic        start;
  logic        abort;
  logic        cmpl;
  logic [3:0]  bi;
  logic [31:0] rd;
  logic        mapped;

  assign s = st_reg.ctl;

  // ----------------------------------------------------------------
  // Pin synchronisers and bit-period ticks
  // ----------------------------------------------------------------
  acs_sync #(
    .W (18)
  ) u_sync (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RST_N_IN),
    .ce_in    (CE_IN),
    .d_in     ({RC_OSC_IN, COMP_IN, PIN_LEVEL_IN}),
    .q_out    (sync_q)
  );

  assign pins   = sync_q[15:0];
  assign comp   = sync_q[16];
  assign rc_lvl = sync_q[17];

  acs_tad_gen u_tad (
    .clk_in     (REF_CLK_IN),
    .rst_n_in   (RST_N_IN),
    .ce_in      (CE_IN),
    .restart_in (restart),
    .sel_in     (s.c1.csel),
    .rc_in      (rc_lvl),
    .tick_out   (tick)
  );

  // ----------------------------------------------------------------
  // Analog pin map from port configuration
  // ----------------------------------------------------------------
  function automatic logic [15:0] ana_mask(input logic [2:0] pc);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      if (pc != 3'h7 && i < 8 - int'(pc))
      begin
        m[i]     = 1'b1;
        m[i + 8] = 1'b1;
      end
    end
    return m;
  endfunction : ana_mask

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign idx      = PADDR_IN[7:2];
  assign acc      = PSEL_IN & PENABLE_IN & s.pready;
  assign wr       = acc & PWRITE_IN;
  assign w0       = wr && idx == IDX_CTRL0;
  assign busy     = s.ph == PH_DELAY || s.ph == PH_FIRST
                    || s.ph == PH_CONV;
  // Non-RC clock cannot run through sleep
  assign pd_sleep = SLEEP_IN && s.c1.csel != CSEL_RC;
  // Go is only honoured once the converter was already on
  assign start    = w0 && PWDATA_IN[C0_GO_BIT] && s.c0.on
                    && PWDATA_IN[C0_ON_BIT] && s.ph == PH_IDLE
                    && !pd_sleep && !s.slp_off;
  assign abort    = w0 && !PWDATA_IN[C0_GO_BIT] && busy;
  assign restart  = start && s.c1.csel != CSEL_RC;
  assign cmpl     = s.ph == PH_CONV && tick && s.tads == CONV_TADS - 4'h1
                    && s.c0.on && !pd_sleep && !abort;
  assign bi       = RES_BITS - s.tads;
  assign mapped   = idx == IDX_CTRL0 || idx == IDX_CTRL1
                    || idx == IDX_RESL || idx == IDX_RESH
                    || idx == IDX_FLAGS || idx == IDX_PORT;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rd = 32'h0000_0000;
    unique case (idx)
      IDX_CTRL0:
      begin
        rd[C0_CHAN_LSB +: 4] = s.c0.chan;
        rd[C0_GO_BIT]        = s.c0.go;
        rd[C0_ON_BIT]        = s.c0.on;
      end
      IDX_CTRL1:
      begin
        rd[C1_CSEL_LSB +: 2] = s.c1.csel;
        rd[C1_FMT_BIT]       = s.c1.fmt;
        rd[C1_PCFG_LSB +: 4] = s.c1.pcfg;
      end
      IDX_RESL: rd[7:0] = st_reg.res_lo;
      IDX_RESH: rd[7:0] = st_reg.res_hi;
      IDX_FLAGS:
      begin
        rd[FL_IRQEN_BIT] = s.fl.irqen;
        rd[FL_DONE_BIT]  = s.fl.done;
      end
      // Analog pins read low
      IDX_PORT: rd[15:0] = pins & ~ana_mask(s.c1.pcfg[3:1]);
      default:  rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next            = st_reg;
    st_next.ctl.wake   = 1'b0;
    st_next.ctl.pready = 1'b0;

    // Bus: one wait state, data and error land with ready
    if (PSEL_IN && PENABLE_IN && !s.pready)
    begin
      st_next.ctl.pready  = 1'b1;
      st_next.ctl.pslverr = !mapped;
      st_next.ctl.prdata  = PWRITE_IN ? 32'h0000_0000 : rd;
    end

    if (w0)
    begin
      st_next.ctl.c0.chan = PWDATA_IN[C0_CHAN_LSB +: 4];
      st_next.ctl.c0.on   = PWDATA_IN[C0_ON_BIT];
      st_next.ctl.c0.go   = start
                            || (busy && PWDATA_IN[C0_GO_BIT]);
    end
    if (wr && idx == IDX_CTRL1)
    begin
      st_next.ctl.c1.csel = PWDATA_IN[C1_CSEL_LSB +: 2];
      st_next.ctl.c1.fmt  = PWDATA_IN[C1_FMT_BIT];
      st_next.ctl.c1.pcfg = PWDATA_IN[C1_PCFG_LSB +: 4];
    end
    if (wr && idx == IDX_FLAGS)
    begin
      st_next.ctl.fl.irqen = PWDATA_IN[FL_IRQEN_BIT];
      st_next.ctl.fl.done  = PWDATA_IN[FL_DONE_BIT];
    end
    // Free software storage whenever no result is landing
    if (wr && idx == IDX_RESL)
      st_next.res_lo = PWDATA_IN[7:0];
    if (wr && idx == IDX_RESH)
      st_next.res_hi = PWDATA_IN[7:0];

    // Sequencer
    unique case (s.ph)
      PH_IDLE:
      begin
        if (start && s.c1.csel == CSEL_RC)
        begin
          st_next.ctl.ph  = PH_DELAY;
          st_next.ctl.dly = 3'h0;
        end
        else if (start)
          st_next.ctl.ph = PH_FIRST;
      end
      PH_DELAY:
      begin
        // Lets a following sleep instruction execute first
        if (s.dly == INSTR_CYC - 3'h1)
          st_next.ctl.ph = PH_FIRST;
        else
          st_next.ctl.dly = s.dly + 3'h1;
      end
      PH_FIRST:
      begin
        if (tick)
        begin
          st_next.ctl.ph   = PH_CONV;
          st_next.ctl.tads = 4'h1;
          st_next.ctl.sar  = 10'h200;
        end
      end
      PH_CONV:
      begin
        if (cmpl)
        begin
          // Whatever level is on the pin gets converted
          st_next.ctl.ph    = PH_HOLD;
          st_next.ctl.tads  = 4'h0;
          st_next.ctl.c0.go = 1'b0;
          st_next.ctl.fl.done = 1'b1;
          if (s.c1.fmt)
          begin
            st_next.res_hi = {6'h00, s.sar[9:8]};
            st_next.res_lo = s.sar[7:0];
          end
          else
          begin
            st_next.res_hi = s.sar[9:2];
            st_next.res_lo = {s.sar[1:0], 6'h00};
          end
          if (SLEEP_IN && s.fl.irqen)
            st_next.ctl.wake = 1'b1;
          else if (SLEEP_IN)
            st_next.ctl.slp_off = 1'b1;
        end
        else if (tick)
        begin
          st_next.ctl.sar[bi] = comp;
          if (bi != 4'h0)
            st_next.ctl.sar[bi - 4'h1] = 1'b1;
          st_next.ctl.tads = s.tads + 4'h1;
        end
      end
      PH_HOLD:
      begin
        // Capacitor stays off the pin for the whole wait
        if (tick && s.tads == HOLD_TADS - 4'h1)
          st_next.ctl.ph = PH_IDLE;
        else if (tick)
          st_next.ctl.tads = s.tads + 4'h1;
      end
      default: st_next.ctl.ph = PH_IDLE;
    endcase

    // Abort leaves results untouched
    if (abort)
    begin
      st_next.ctl.ph   = PH_HOLD;
      st_next.ctl.tads = 4'h0;
    end
    // Sleep on a non-RC clock kills the conversion; on bit stays
    if (pd_sleep && (busy || s.c0.go))
    begin
      st_next.ctl.ph    = PH_IDLE;
      st_next.ctl.c0.go = 1'b0;
    end
    if (!st_next.ctl.c0.on)
    begin
      st_next.ctl.ph    = PH_IDLE;
      st_next.ctl.c0.go = 1'b0;
    end
    if (!SLEEP_IN)
      st_next.ctl.slp_off = 1'b0;

    st_next.ctl.power  = st_next.ctl.c0.on && !pd_sleep
                         && !st_next.ctl.slp_off;
    st_next.ctl.sample = st_next.ctl.power
                         && st_next.ctl.ph == PH_IDLE;
    st_next.ctl.chan_o = st_next.ctl.c0.chan;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Results have no reset: their contents survive any reset
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      st_reg.ctl <= CTL_RST;
    else if (CE_IN)
      st_reg <= st_next;
  end

  assign PRDATA_OUT  = s.prdata;
  assign PREADY_OUT  = s.pready;
  assign PSLVERR_OUT = s.pslverr;
  assign POWER_OUT   = s.power;
  assign SAMPLE_OUT  = s.sample;
  assign CHANNEL_OUT = s.chan_o;
  assign TRIAL_OUT   = s.sar;
  assign WAKE_OUT    = s.wake;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] tick_cnt_reg;

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      tick_cnt_reg <= 4'h0;
    else if (CE_IN && start)
      tick_cnt_reg <= 4'h0;
    else if (CE_IN && tick && busy && s.ph != PH_DELAY)
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN || !CE_IN);

  sequence s_first_min;
    s.ph == PH_FIRST [*4];
  endsequence

  sequence s_first_exit;
    ##[0:61] s.ph != PH_FIRST;
  endsequence

  a_conv_length: assert property (
    cmpl |-> tick_cnt_reg == 4'hB)
    else $error("Conversion did not take twelve periods");

  a_first_seg: assert property (
    (start && s.c1.csel != CSEL_RC) |=> s_first_min ##0 s_first_exit)
    else $error("First segment length out of range");

  a_rc_delay: assert property (
    (start && s.c1.csel == CSEL_RC) |=> s.ph == PH_DELAY [*4]
      ##1 s.ph != PH_CONV)
    else $error("RC start not delayed by instruction cycle");

  a_abort_keep: assert property (
    (abort && PWDATA_IN[C0_ON_BIT] && !pd_sleep)
      |=> st_reg.res_hi == $past(st_reg.res_hi)
      && st_reg.res_lo == $past(st_reg.res_lo) && s.ph == PH_HOLD)
    else $error("Abort disturbed results");

  a_hold_wait: assert property (
    (s.ph == PH_HOLD) |-> !SAMPLE_OUT)
    else $error("Capacitor connected during hold wait");

  a_done_flags: assert property (
    cmpl |=> !s.c0.go && s.fl.done)
    else $error("Completion flags wrong");

  a_right_just: assert property (
    (cmpl && s.c1.fmt) |=> st_reg.res_hi[7:2] == 6'h00
      && st_reg.res_lo == $past(s.sar[7:0]))
    else $error("Right-justified result wrong");

  a_left_just: assert property (
    (cmpl && !s.c1.fmt) |=> st_reg.res_lo[5:0] == 6'h00
      && st_reg.res_hi == $past(s.sar[9:2]))
    else $error("Left-justified result wrong");

  a_sleep_wake: assert property (
    (cmpl && SLEEP_IN && s.fl.irqen) |=> WAKE_OUT ##1 !WAKE_OUT)
    else $error("No wake pulse after sleep conversion");

  a_sleep_off: assert property (
    (cmpl && SLEEP_IN && !s.fl.irqen && !$past(abort))
      |=> !POWER_OUT && (s.c0.on || !SLEEP_IN))
    else $error("Converter not powered down after sleep");

  a_sleep_abort: assert property (
    (SLEEP_IN && s.c1.csel != CSEL_RC && busy)
      |=> s.ph == PH_IDLE && !POWER_OUT)
    else $error("Sleep did not abort non-RC conversion");

  a_off_power: assert property (
    !s.c0.on |-> !POWER_OUT && !SAMPLE_OUT && s.ph == PH_IDLE)
    else $error("Converter active while off");

endmodule : acs_seq

`default_nettype wire

// File: rtl/acs_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none

module acs_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_in,   // Core clock
  input  wire logic         rst_n_in, // Async reset, low
  input  wire logic         ce_in,    // Clock enable
  input  wire logic [W-1:0] d_in,     // Asynchronous levels
  output logic      [W-1:0] q_out     // Synchronised levels
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= '0;
      q_out    <= '0;
    end
    else if (ce_in)
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule : acs_sync

`default_nettype wire

// File: rtl/acs_tad_gen.sv
// Bit-period tick generator: oscillator divider or RC edge
`timescale 1ns/10ps
`default_nettype none

module acs_tad_gen
  import acs_pkg::*;
(
  input  wire logic       clk_in,     // Core clock
  input  wire logic       rst_n_in,   // Async reset, low
  input  wire logic       ce_in,      // Clock enable
  input  wire logic       restart_in, // Realign divider
  input  wire logic [1:0] sel_in,     // Clock select code
  input  wire logic       rc_in,      // Synchronised RC clock
  output logic            tick_out    // One-cycle period tick
);

  acs_tad_st_t st_reg;
  acs_tad_st_t st_next;
  logic [6:0]  div;

  always_comb
  begin
    st_next      = st_reg;
    st_next.rc_q = rc_in;
    st_next.tick = 1'b0;
    case (sel_in)
      CSEL_D32: div = DIV_32;
      CSEL_D64: div = DIV_64;
      default:  div = DIV_8;
    endcase
    // Restart loads one so the first tick lands exactly one period on
    if (restart_in)
      st_next.cnt = 7'h01;
    else if (sel_in == CSEL_RC)
      st_next.tick = rc_in & ~st_reg.rc_q;
    else if (st_reg.cnt >= div - 7'h01)
    begin
      st_next.cnt  = 7'h00;
      st_next.tick = 1'b1;
    end
    else
      st_next.cnt = st_reg.cnt + 7'h01;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_reg <= TAD_RST;
    else if (ce_in)
      st_reg <= st_next;
  end

  assign tick_out = st_reg.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] gap_reg;
  logic       d8_run_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gap_reg    <= 4'h0;
      d8_run_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (tick_out)
        gap_reg <= 4'h0;
      else if (gap_reg != 4'hF)
        gap_reg <= gap_reg + 4'h1;
      // Spacing only judged while divide-by-8 held since the last tick
      if (tick_out)
        d8_run_reg <= sel_in == CSEL_D8 && !restart_in;
      else if (sel_in != CSEL_D8 || restart_in)
        d8_run_reg <= 1'b0;
    end
  end

  a_div_eight: assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (d8_run_reg && sel_in == CSEL_D8 && !restart_in)
      |-> (tick_out ? gap_reg == 4'h7 : gap_reg < 4'h7))
    else $error("Divide-by-8 tick spacing wrong");

endmodule : acs_tad_gen

`default_nettype wire

// File: verification/acs_analog_model.sv
// Analog input pin model driving the successive-approximation comparator
`timescale 1ns/10ps
`default_nettype none

module acs_analog_model
(
  input  wire logic [9:0] trial_in, // Trial code from converter
  input  wire logic [9:0] level_in, // Level on selected pin
  output logic            comp_out  // High when level >= trial
);
  // Digital and driven pins reach the comparator like any level
  assign comp_out = (level_in >= trial_in);
endmodule : acs_analog_model

`default_nettype wire

// File: verification/tb_acs_seq.sv
// Self-checking testbench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none

module tb_acs_seq;
  import acs_pkg::*;
  typedef struct packed {
    logic w; logic [7:0] a; logic [7:0] d; logic [15:0] e; logic err;
  } acs_row_t;
  logic clk, rst_n, psel, pen, pwr, sleep, comp, rc;
  logic pow, smp, wake, prdy, perr, lerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pins;
  logic [9:0] lvl, trial;
  logic [3:0] chan;
  int error_cnt = 0, samples_checked = 0, cyc = 0, t0, n;
  int minc[4] = '{96, 384, 768, 0};
  acs_row_t rows[8];

  acs_seq acs_seq_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .SLEEP_IN(sleep), .PIN_LEVEL_IN(pins),
    .COMP_IN(comp), .RC_OSC_IN(rc), .POWER_OUT(pow), .SAMPLE_OUT(smp),
    .CHANNEL_OUT(chan), .TRIAL_OUT(trial), .WAKE_OUT(wake));
  acs_analog_model acs_analog_model_inst (.trial_in(trial), .level_in(lvl),
    .comp_out(comp));

  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Internal RC clock, unrelated in phase to the core clock
  initial
  begin
    rc = 0;
    forever #21 rc = ~rc;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1;
    forever
    begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    rd = prdata;
    lerr = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb

  task end_sim;
    $display("Errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // One conversion on the given clock source and result format
  // ----------------------------------------------------------------
  task conv(input logic [1:0] cs, input logic fmt);
    apb(1, 8'h54, {cs, fmt, 5'h0E});
    apb(1, 8'h60, 8'h00);
    apb(1, 8'h50, 8'h05);
    t0 = cyc;
    do apb(0, 8'h50, 8'h00); while (rd[2] === 1'b1);
    chk(32'(cyc - t0 >= minc[cs]), 32'h1);
    apb(0, 8'h5C, 8'h00);
    chk(rd, fmt ? {30'h0, lvl[9:8]} : {24'h0, lvl[9:2]});
    apb(0, 8'h58, 8'h00);
    chk(rd, fmt ? {24'h0, lvl[7:0]} : {24'h0, lvl[1:0], 6'h0});
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h1);
    while (smp !== 1'b1) @(posedge clk);
  endtask : conv

  initial
  begin
    #200000;
    error_cnt++;
    end_sim;
  end

  initial
  begin
    rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 8'h00; pwdata = 32'h0;
    sleep = 0; pins = 16'hFFFF; lvl = 10'h2B5;
    rows = '{'{0, 8'h50, 8'h00, 16'h0000, 0}, '{0, 8'h54, 8'h00, 16'h0, 0},
             '{0, 8'h60, 8'h00, 16'h0000, 0}, '{0, 8'h64, 8'h00, 16'h0, 0},
             '{1, 8'h54, 8'h1E, 16'h0000, 0}, '{0, 8'h54, 8'h0, 16'h0E, 0},
             '{0, 8'h64, 8'h00, 16'hFFFF, 0}, '{0, 8'h40, 8'h0, 16'h0, 1}};
    repeat (2) @(posedge clk);
    rst_n <= 1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, {16'h0, rows[i].e});
      chk({31'h0, lerr}, {31'h0, rows[i].err});
    end
    apb(1, 8'h58, 8'hA5);
    apb(0, 8'h58, 8'h00);
    chk(rd, 32'hA5);
    apb(1, 8'h50, 8'h05);
    apb(0, 8'h50, 8'h00);
    chk(rd, 32'h1);
    for (int c = 0; c < 4; c++) conv(2'(c), c[0]);
    // Abort mid-conversion: result keeps the software value
    apb(1, 8'h54, 8'h20);
    apb(1, 8'h60, 8'h00);
    apb(1, 8'h58, 8'h3C);
    apb(1, 8'h50, 8'h05);
    repeat (20) @(posedge clk);
    apb(1, 8'h50, 8'h01);
    repeat (200) @(posedge clk);
    chk({31'h0, smp}, 32'h1);
    apb(0, 8'h58, 8'h00);
    chk(rd, 32'h3C);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h0);
    // Sleep on a divided clock aborts and powers down
    apb(1, 8'h50, 8'h05);
    repeat (20) @(posedge clk);
    sleep <= 1;
    repeat (10) @(posedge clk);
    chk({31'h0, pow}, 32'h0);
    sleep <= 0;
    apb(0, 8'h50, 8'h00);
    chk(rd, 32'h1);
    // RC clock through sleep: wake with irq enabled, else power down
    apb(1, 8'h54, 8'hE0);
    apb(1, 8'h60, 8'h02);
    apb(1, 8'h50, 8'h15);
    sleep <= 1;
    for (n = 0; n < 2000 && wake !== 1'b1; n++) @(posedge clk);
    chk({31'h0, wake}, 32'h1);
    chk({28'h0, chan}, 32'h1);
    sleep <= 0;
    apb(0, 8'h50, 8'h00);
    chk(rd, 32'h11);
    apb(0, 8'h58, 8'h00);
    chk(rd, {24'h0, lvl[7:0]});
    while (smp !== 1'b1) @(posedge clk);
    apb(1, 8'h60, 8'h00);
    apb(1, 8'h50, 8'h15);
    sleep <= 1;
    for (n = 0; n < 2000 && pow !== 1'b0; n++) @(posedge clk);
    chk({31'h0, pow}, 32'h0);
    apb(0, 8'h50, 8'h00);
    chk(rd, 32'h11);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h1);
    sleep <= 0;
    repeat (2) @(posedge clk);
    chk({31'h0, pow}, 32'h1);
    // Mid-run reset: control back to reset values, results survive
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    chk({31'h0, pow}, 32'h0);
    apb(0, 8'h5C, 8'h00);
    chk(rd, {30'h0, lvl[9:8]});
    apb(0, 8'h50, 8'h00);
    chk(rd, 32'h0);
    end_sim;
  end
endmodule : tb_acs_seq

`default_nettype wire
